// ### shared/rtc_value_pkg.sv
// Constants for the calendar clock value and alarm match windows.
// Assumes a CPU that reaches the values through four byte-wide window ports.
// Notes on behaviour
// R01: Year holds tens digit in bits 7-4 and units digit in bits 3-0.
// R02: Month holds tens bit at 4, units in 3-0; bits 7-5 read zero.
// R03: Date holds tens in 5-4, units in 3-0; bits 7-6 read zero.
// R04: Weekday holds one digit in bits 2-0; bits 7-3 read zero.
// R05: Hour holds tens in 5-4, units in 3-0; bits 7-6 read zero.
// R06: Minute holds tens in 6-4, units in 3-0; bit 7 reads zero.
// R07: Second holds tens in 6-4, units in 3-0; bit 7 reads zero.
// R08: Reserved time slot stores nothing, reads zero, ignores writes.
// R09: Every unimplemented bit reads back as zero.
// R10: Calendar and alarm calendar writes only land while write unlock is set.
// R11: Alarm month match uses the month layout.
// R12: Alarm date match uses the date layout.
// R13: Alarm weekday match uses the weekday layout.
// R14: Stored values have no defined content after reset.
// R15: Time pointer picks the slot pair; high port access decrements it to 00.
// R16: Alarm pointer picks the alarm pair; high port access decrements it to 00.
// R17: Time window writes to a stored slot while locked are discarded and flagged on wr_discarded_q.
package rtc_value_pkg;

  // Window pointer codes
  localparam logic [1:0] PTR_ZERO = 2'h0;
  localparam logic [1:0] PTR_ONE = 2'h1;
  localparam logic [1:0] PTR_TWO = 2'h2;
  localparam logic [1:0] PTR_THREE = 2'h3;
  localparam logic [1:0] PTR_RESET = 2'h0;

  // Storage slot indices
  localparam int SLOT_COUNT = 13;
  localparam logic [3:0] SLOT_SECOND = 4'h0;
  localparam logic [3:0] SLOT_MINUTE = 4'h1;
  localparam logic [3:0] SLOT_HOUR = 4'h2;
  localparam logic [3:0] SLOT_WEEKDAY = 4'h3;
  localparam logic [3:0] SLOT_DATE = 4'h4;
  localparam logic [3:0] SLOT_MONTH = 4'h5;
  localparam logic [3:0] SLOT_YEAR = 4'h6;
  localparam logic [3:0] SLOT_ALM_SECOND = 4'h7;
  localparam logic [3:0] SLOT_ALM_MINUTE = 4'h8;
  localparam logic [3:0] SLOT_ALM_HOUR = 4'h9;
  localparam logic [3:0] SLOT_ALM_WEEKDAY = 4'hA;
  localparam logic [3:0] SLOT_ALM_DATE = 4'hB;
  localparam logic [3:0] SLOT_ALM_MONTH = 4'hC;
  localparam logic [3:0] SLOT_NONE = 4'hF;

  // Implemented bit masks of each layout
  localparam logic [7:0] MASK_YEAR = 8'hFF;
  localparam logic [7:0] MASK_MONTH = 8'h1F;
  localparam logic [7:0] MASK_DATE = 8'h3F;
  localparam logic [7:0] MASK_WEEKDAY = 8'h07;
  localparam logic [7:0] MASK_HOUR = 8'h3F;
  localparam logic [7:0] MASK_MINUTE = 8'h7F;
  localparam logic [7:0] MASK_SECOND = 8'h7F;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [7:0] RD_DATA_RESET = 8'h00;

  // Slots whose writes need the unlock bit (time minute and second are
  // gated by the whole time window lock, alarm minute and second are free)
  localparam logic [SLOT_COUNT-1:0] SLOT_LOCKED = 13'h1E7F;

  // Mask of a slot, by index
  function automatic logic [7:0] slot_mask(input logic [3:0] slot);
    logic [7:0] m;
    m = READ_ZERO;
    case (slot)
      SLOT_SECOND, SLOT_ALM_SECOND: m = MASK_SECOND;
      SLOT_MINUTE, SLOT_ALM_MINUTE: m = MASK_MINUTE;
      SLOT_HOUR, SLOT_ALM_HOUR: m = MASK_HOUR;
      SLOT_WEEKDAY, SLOT_ALM_WEEKDAY: m = MASK_WEEKDAY;
      SLOT_DATE, SLOT_ALM_DATE: m = MASK_DATE;
      SLOT_MONTH, SLOT_ALM_MONTH: m = MASK_MONTH;
      SLOT_YEAR: m = MASK_YEAR;
      default: m = READ_ZERO;
    endcase
    return m;
  endfunction : slot_mask

endpackage : rtc_value_pkg

// ### hdl/bcd_slot.sv
// One stored BCD value byte with fixed implemented bits.
// Assumes the parent decides when a write is allowed.
`timescale 1ns/1ps
module bcd_slot
  import rtc_value_pkg::*;
#(
  parameter logic [7:0] MASK = 8'hFF
)
(
  // Clock and freeze
  input wire logic mclk,
  input wire logic ce,
  // Write side
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  // Stored value
  output logic [7:0] value_q
);

  logic [7:0] value_d;

  // Unimplemented positions are forced to zero on entry
  always_comb
  begin
    value_d = wr_data & MASK; // [R09]
  end

  // No reset: content is unknown until software writes it
  always_ff @(posedge mclk)
  begin
    if (ce && wr_en)
    begin
      value_q <= value_d; // [R14]
    end
  end

endmodule : bcd_slot

// ### hdl/rtc_value_regs.sv
// Calendar clock value and alarm match registers behind window ports.
// Assumes the CPU issues at most one window access per cycle.
// Assumes every strobe is synchronous to mclk and lasts one clock per access.
// Assumes the unlock bit comes from a control register outside this block.
`timescale 1ns/1ps
module rtc_value_regs
  import rtc_value_pkg::*;
(
  // Clock, reset and freeze
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // Configuration from the control register
  input wire logic value_write_unlock,
  input wire logic time_ptr_load,
  input wire logic [1:0] time_ptr_value,
  input wire logic alarm_ptr_load,
  input wire logic [1:0] alarm_ptr_value,
  // Time window access strobes
  input wire logic time_hi_rd,
  input wire logic time_hi_wr,
  input wire logic time_lo_rd,
  input wire logic time_lo_wr,
  // Alarm window access strobes
  input wire logic alarm_hi_rd,
  input wire logic alarm_hi_wr,
  input wire logic alarm_lo_rd,
  input wire logic alarm_lo_wr,
  // Shared write data
  input wire logic [7:0] wr_data,
  // Read answer and dropped-write flag
  output logic [7:0] rd_data_q,
  output logic rd_valid_q,
  output logic wr_discarded_q,
  // Window pointers
  output logic [1:0] time_window_pointer_q,
  output logic [1:0] alarm_window_pointer_q,
  // Time values
  output logic [7:0] second_count_q,
  output logic [7:0] minute_count_q,
  output logic [7:0] hour_count_q,
  output logic [7:0] weekday_count_q,
  output logic [7:0] date_count_q,
  output logic [7:0] month_count_q,
  output logic [7:0] year_count_q,
  // Alarm match values
  output logic [7:0] alarm_second_match_q,
  output logic [7:0] alarm_minute_match_q,
  output logic [7:0] alarm_hour_match_q,
  output logic [7:0] alarm_weekday_match_q,
  output logic [7:0] alarm_date_match_q,
  output logic [7:0] alarm_month_match_q
);

  // Pointer step: count down, hold at zero
  // The pointer never wraps, so repeated high-port accesses settle on 00
  function automatic logic [1:0] ptr_step(input logic [1:0] ptr);
    logic [1:0] n;
    n = ptr;
    if (ptr != PTR_ZERO)
    begin
      n = ptr - 2'h1;
    end
    return n;
  endfunction : ptr_step

  // Slot chosen by a time window port and pointer
  // High port at 11 maps to no slot; it reads zero and stores nothing
  function automatic logic [3:0] time_slot(input logic hi, input logic [1:0] ptr);
    logic [3:0] s;
    s = SLOT_NONE;
    unique case (ptr)
      PTR_ZERO: s = hi ? SLOT_MINUTE : SLOT_SECOND;
      PTR_ONE: s = hi ? SLOT_WEEKDAY : SLOT_HOUR;
      PTR_TWO: s = hi ? SLOT_MONTH : SLOT_DATE;
      PTR_THREE: s = hi ? SLOT_NONE : SLOT_YEAR;
    endcase
    return s;
  endfunction : time_slot

  // Slot chosen by an alarm window port and pointer
  // Pointer 11 has no alarm pair on either port
  function automatic logic [3:0] alarm_slot(input logic hi, input logic [1:0] ptr);
    logic [3:0] s;
    s = SLOT_NONE;
    unique case (ptr)
      PTR_ZERO: s = hi ? SLOT_ALM_MINUTE : SLOT_ALM_SECOND;
      PTR_ONE: s = hi ? SLOT_ALM_WEEKDAY : SLOT_ALM_HOUR;
      PTR_TWO: s = hi ? SLOT_ALM_MONTH : SLOT_ALM_DATE;
      PTR_THREE: s = SLOT_NONE;
    endcase
    return s;
  endfunction : alarm_slot

  // Next-state, decode and answer nets
  logic [1:0] time_ptr_d;
  logic [1:0] alarm_ptr_d;
  logic [3:0] wr_slot;
  logic [3:0] rd_slot;
  logic wr_any;
  logic rd_any;
  logic wr_allowed;
  logic [7:0] rd_data_d;
  logic wr_discarded_d;
  logic [SLOT_COUNT-1:0] slot_wr;
  logic [7:0] slot_value [SLOT_COUNT];

  // Which slot a write targets; the reserved pair gives no slot
  // Fixed port priority keeps to one slot write per cycle
  always_comb
  begin
    wr_slot = SLOT_NONE;
    wr_any = 1'b0;
    if (time_hi_wr)
    begin
      wr_slot = time_slot(1'b1, time_window_pointer_q); // [R15]
      wr_any = 1'b1;
    end
    else if (time_lo_wr)
    begin
      wr_slot = time_slot(1'b0, time_window_pointer_q); // [R15]
      wr_any = 1'b1;
    end
    else if (alarm_hi_wr)
    begin
      wr_slot = alarm_slot(1'b1, alarm_window_pointer_q); // [R16]
      wr_any = 1'b1;
    end
    else if (alarm_lo_wr)
    begin
      wr_slot = alarm_slot(1'b0, alarm_window_pointer_q); // [R16]
      wr_any = 1'b1;
    end
  end

  // Lock check: gated slots need the unlock bit set
  // Alarm minute and second stay writable so software can tune them freely
  always_comb
  begin
    wr_allowed = 1'b0;
    if (wr_slot != SLOT_NONE)
    begin
      wr_allowed = value_write_unlock || !SLOT_LOCKED[wr_slot]; // [R10] [R17]
    end
  end

  // Dropped write report; the reserved pair never raises it
  always_comb
  begin
    wr_discarded_d = wr_any && (wr_slot != SLOT_NONE) && !wr_allowed; // [R17]
  end

  // One write strobe per slot
  // A write to no slot raises no strobe, so nothing is stored
  always_comb
  begin
    slot_wr = '0;
    if (wr_allowed)
    begin
      slot_wr[wr_slot] = 1'b1; // [R08]
    end
  end

  // Storage slots, each with the layout mask of its value
  // Masking at the write keeps unused bits zero in the stored flops too
  for (genvar i = 0; i < SLOT_COUNT; i++)
  begin : g_slot
    bcd_slot #(
      .MASK(slot_mask(4'(i))) // [R01] [R02] [R03] [R04] [R05] [R06] [R07] [R11] [R12] [R13]
    ) u_slot (
      .mclk(mclk),
      .ce(ce),
      .wr_en(slot_wr[i]),
      .wr_data(wr_data),
      .value_q(slot_value[i])
    );
  end

  // Which slot a read targets
  // Same priority as the write side, so reads and writes decode alike
  always_comb
  begin
    rd_slot = SLOT_NONE;
    rd_any = 1'b0;
    if (time_hi_rd)
    begin
      rd_slot = time_slot(1'b1, time_window_pointer_q); // [R15]
      rd_any = 1'b1;
    end
    else if (time_lo_rd)
    begin
      rd_slot = time_slot(1'b0, time_window_pointer_q); // [R15]
      rd_any = 1'b1;
    end
    else if (alarm_hi_rd)
    begin
      rd_slot = alarm_slot(1'b1, alarm_window_pointer_q); // [R16]
      rd_any = 1'b1;
    end
    else if (alarm_lo_rd)
    begin
      rd_slot = alarm_slot(1'b0, alarm_window_pointer_q); // [R16]
      rd_any = 1'b1;
    end
  end

  // Read mux; the reserved and unused slots answer zero
  // Masking here too zeroes unused bits even before a slot is first written
  always_comb
  begin
    rd_data_d = READ_ZERO; // [R08]
    if (rd_slot != SLOT_NONE)
    begin
      rd_data_d = slot_value[rd_slot] & slot_mask(rd_slot); // [R09]
    end
  end

  // Read pulse, one cycle after the strobe
  // Raised for the reserved pair too, since that read is still answered
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_valid_q <= 1'b0;
    end
    else if (ce)
    begin
      rd_valid_q <= rd_any;
    end
  end

  // Read data, held until the next read
  // Holding keeps the answer steady for a slow reader between reads
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data_q <= RD_DATA_RESET;
    end
    else if (ce && rd_any)
    begin
      rd_data_q <= rd_data_d;
    end
  end

  // Flag for a write dropped by the lock
  // Lasts one cycle; it belongs to the access that was refused
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_discarded_q <= 1'b0;
    end
    else if (ce)
    begin
      wr_discarded_q <= wr_discarded_d; // [R17]
    end
  end

  // Next time pointer: a load wins over the access step
  // A refused write still steps the pointer, like any high-port access
  always_comb
  begin
    time_ptr_d = time_window_pointer_q;
    if (time_ptr_load)
    begin
      time_ptr_d = time_ptr_value;
    end
    else if (time_hi_rd || time_hi_wr)
    begin
      time_ptr_d = ptr_step(time_window_pointer_q); // [R15]
    end
  end

  // Next alarm pointer: a load wins over the access step
  // The alarm pointer stops at 00; there is no roll-over here
  always_comb
  begin
    alarm_ptr_d = alarm_window_pointer_q;
    if (alarm_ptr_load)
    begin
      alarm_ptr_d = alarm_ptr_value;
    end
    else if (alarm_hi_rd || alarm_hi_wr)
    begin
      alarm_ptr_d = ptr_step(alarm_window_pointer_q); // [R16]
    end
  end

  // Time pointer register
  // Reset puts it on the minute and second pair
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      time_window_pointer_q <= PTR_RESET;
    end
    else if (ce)
    begin
      time_window_pointer_q <= time_ptr_d; // [R15]
    end
  end

  // Alarm pointer register
  // Kept apart from the time pointer so each window moves on its own
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alarm_window_pointer_q <= PTR_RESET;
    end
    else if (ce)
    begin
      alarm_window_pointer_q <= alarm_ptr_d; // [R16]
    end
  end

  // Time values straight out of the slot flops
  // No reset here: a value reads unknown until software writes it
  assign second_count_q = slot_value[SLOT_SECOND];
  assign minute_count_q = slot_value[SLOT_MINUTE];
  assign hour_count_q = slot_value[SLOT_HOUR];
  assign weekday_count_q = slot_value[SLOT_WEEKDAY];
  assign date_count_q = slot_value[SLOT_DATE];
  assign month_count_q = slot_value[SLOT_MONTH];
  assign year_count_q = slot_value[SLOT_YEAR];

  // Alarm match values straight out of their slot flops
  // Alarm slots are kept apart so a time write never lands on them
  assign alarm_second_match_q = slot_value[SLOT_ALM_SECOND];
  assign alarm_minute_match_q = slot_value[SLOT_ALM_MINUTE];
  assign alarm_hour_match_q = slot_value[SLOT_ALM_HOUR];
  assign alarm_weekday_match_q = slot_value[SLOT_ALM_WEEKDAY];
  assign alarm_date_match_q = slot_value[SLOT_ALM_DATE];
  assign alarm_month_match_q = slot_value[SLOT_ALM_MONTH];

endmodule : rtc_value_regs

// ### tb/rtc_value_regs_monitor.sv
// Port checker for the value window registers.
// Assumes it is bound to every rtc_value_regs instance.
`timescale 1ns/1ps
module rtc_value_regs_monitor
  import rtc_value_pkg::*;
(
  // Clock and control
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic value_write_unlock,
  input wire logic time_ptr_load,
  input wire logic [1:0] time_ptr_value,
  input wire logic alarm_ptr_load,
  input wire logic [1:0] alarm_ptr_value,
  // Strobes and data
  input wire logic time_hi_rd,
  input wire logic time_hi_wr,
  input wire logic time_lo_rd,
  input wire logic time_lo_wr,
  input wire logic alarm_hi_rd,
  input wire logic alarm_hi_wr,
  input wire logic alarm_lo_rd,
  input wire logic [7:0] wr_data,
  // Answers and values
  input wire logic [7:0] rd_data_q,
  input wire logic rd_valid_q,
  input wire logic wr_discarded_q,
  input wire logic [1:0] time_window_pointer_q,
  input wire logic [1:0] alarm_window_pointer_q,
  input wire logic [7:0] year_count_q,
  input wire logic [7:0] month_count_q,
  input wire logic [7:0] alarm_minute_match_q
);
  logic rd_any;
  logic [1:0] tp;
  logic [1:0] ap;

  // Any read strobe, and short pointer names
  assign rd_any = time_hi_rd | time_lo_rd | alarm_hi_rd | alarm_lo_rd;
  assign tp = time_window_pointer_q;
  assign ap = alarm_window_pointer_q;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  AST_RD_VALID: assert property (ce |=> rd_valid_q == $past(rd_any))
    else $error("read pulse wrong");
  AST_TPTR_STEP: assert property (ce && (time_hi_rd || time_hi_wr) && !time_ptr_load
    |=> tp == (($past(tp) == 2'h0) ? 2'h0 : $past(tp) - 2'h1)) else $error("time step");
  AST_APTR_STEP: assert property (ce && (alarm_hi_rd || alarm_hi_wr) && !alarm_ptr_load
    |=> ap == (($past(ap) == 2'h0) ? 2'h0 : $past(ap) - 2'h1)) else $error("alarm step");
  AST_TPTR_LO: assert property (ce && !time_hi_rd && !time_hi_wr && !time_ptr_load
    |=> $stable(tp)) else $error("time pointer moved");
  AST_RSVD_ZERO: assert property (ce && time_hi_rd && tp == 2'h3
    |=> rd_data_q == 8'h00) else $error("reserved read");
  AST_LOCK_DROP: assert property (ce && !value_write_unlock && time_lo_wr && !time_hi_wr
    && tp == 2'h3 |=> $stable(year_count_q) && wr_discarded_q) else $error("locked write");
  AST_YEAR_WR: assert property (ce && value_write_unlock && time_lo_wr && !time_hi_wr
    && tp == 2'h3 |=> year_count_q == $past(wr_data)) else $error("year write");
  AST_MONTH_WR: assert property (ce && value_write_unlock && time_hi_wr && tp == 2'h2
    |=> month_count_q == ($past(wr_data) & 8'h1F)) else $error("month write");
  AST_ALM_MIN: assert property (ce && alarm_hi_wr && !time_hi_wr && !time_lo_wr && ap == 2'h0
    |=> alarm_minute_match_q == ($past(wr_data) & 8'h7F)) else $error("alarm minute");
  AST_TPTR_LOAD: assert property (ce && time_ptr_load |=> tp == $past(time_ptr_value))
    else $error("time pointer load");
  AST_APTR_LOAD: assert property (ce && alarm_ptr_load |=> ap == $past(alarm_ptr_value))
    else $error("alarm pointer load");

  // Main scenarios reached
  cover property (ce && !value_write_unlock && time_lo_wr);
  cover property (ce && time_hi_rd && tp == 2'h3);
  cover property (ce && alarm_hi_wr && ap == 2'h0);
  cover property (ce && time_ptr_load && time_hi_rd);
endmodule : rtc_value_regs_monitor

bind rtc_value_regs rtc_value_regs_monitor mon (.*);

// ### tb/cpu_window_model.sv
// CPU model driving window strobes, pointer loads, unlock and freeze.
// Assumes the bench calls drive at most once per cycle.
`timescale 1ns/1ps
module cpu_window_model
(
  // Clock
  input wire logic mclk,
  // CPU requests
  output logic [7:0] stb,
  output logic [1:0] ld,
  output logic [1:0] pv,
  output logic [7:0] wr_data,
  output logic value_write_unlock,
  output logic ce
);
  // Idle and locked at time zero
  initial
  begin
    stb = 8'h00;
    ld = 2'h0;
    pv = 2'h0;
    wr_data = 8'h00;
    value_write_unlock = 1'b0;
    ce = 1'b1;
  end

  // Set after a falling edge, taken at the next rising edge
  task automatic drive(input logic [7:0] s, input logic [1:0] l, input logic [1:0] p,
    input logic [7:0] d, input logic u, input logic c);
    @(negedge mclk);
    value_write_unlock = u; // Unlock settles ahead of gated writes
    stb = s;
    ld = l;
    pv = p;
    wr_data = d;
    ce = c;
    @(posedge mclk);
    #1;
  endtask : drive
endmodule : cpu_window_model

// ### tb/rtc_value_regs_tb.sv
// Self-checking bench with a reference model of the value windows.
// Assumes the CPU model drives every request input of the block.
`timescale 1ns/1ps
module rtc_value_regs_tb;
  import rtc_value_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ce, unl, rd_valid_q, wr_discarded_q;
  logic [7:0] stb, wd, rd_data_q;
  logic [1:0] ld, pv, tptr, aptr;
  logic [7:0] v [13];
  logic [7:0] rnd = 8'h15;
  int error_cnt = 0;
  int check_count = 0;
  int tp = 0;
  int ap = 0;
  int ul = 0;
  int m [13];
  int msk [13] = '{8'h7F, 8'h7F, 8'h3F, 8'h07, 8'h3F, 8'h1F, 8'hFF,
    8'h7F, 8'h7F, 8'h3F, 8'h07, 8'h3F, 8'h1F};

  // 20 MHz clock
  always #25 mclk = ~mclk;

  cpu_window_model cpu (.mclk(mclk), .stb(stb), .ld(ld), .pv(pv), .wr_data(wd),
    .value_write_unlock(unl), .ce(ce));

  rtc_value_regs dut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .value_write_unlock(unl),
    .time_ptr_load(ld[0]), .time_ptr_value(pv), .alarm_ptr_load(ld[1]),
    .alarm_ptr_value(pv), .time_hi_rd(stb[0]), .time_hi_wr(stb[1]),
    .time_lo_rd(stb[2]), .time_lo_wr(stb[3]), .alarm_hi_rd(stb[4]),
    .alarm_hi_wr(stb[5]), .alarm_lo_rd(stb[6]), .alarm_lo_wr(stb[7]), .wr_data(wd),
    .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .wr_discarded_q(wr_discarded_q),
    .time_window_pointer_q(tptr), .alarm_window_pointer_q(aptr),
    .second_count_q(v[0]), .minute_count_q(v[1]), .hour_count_q(v[2]),
    .weekday_count_q(v[3]), .date_count_q(v[4]), .month_count_q(v[5]),
    .year_count_q(v[6]), .alarm_second_match_q(v[7]), .alarm_minute_match_q(v[8]),
    .alarm_hour_match_q(v[9]), .alarm_weekday_match_q(v[10]),
    .alarm_date_match_q(v[11]), .alarm_month_match_q(v[12]));

  // Next pseudo-random byte
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  // Compare one result and count it
  task automatic chk(input logic [7:0] got, input int exp);
    check_count++;
    if (got !== exp[7:0])
    begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp[7:0]);
    end
  endtask : chk

  // Port p: 0 time high, 1 time low, 2 alarm high, 3 alarm low
  task automatic op(input int p, input int w, input logic [7:0] d, input int c);
    int hi [4] = '{1, 3, 5, -1};
    int lo [4] = '{0, 2, 4, 6};
    int ptr, k, gated;
    ptr = (p < 2) ? tp : ap;
    k = (p % 2 == 0) ? hi[ptr] : lo[ptr];
    if (p >= 2)
      k = (ptr == 3 || k < 0) ? -1 : k + 7;
    gated = (ul == 0 && k >= 0 && k != 7 && k != 8);
    cpu.drive(8'h01 << (2 * p + w), 2'h0, 2'h0, d, ul[0], c[0]);
    if (c != 0)
    begin
      chk(8'(rd_valid_q), 1 - w);
      chk(8'(wr_discarded_q), w * gated);
      if (w == 0)
        chk(rd_data_q, (k < 0) ? 0 : m[k]);
      else if (k >= 0 && gated == 0)
        m[k] = d & msk[k];
      if (w == 1 && k >= 0)
        chk(v[k], m[k]);
      if (p % 2 == 0 && ptr > 0)
        ptr--;
      if (p < 2)
        tp = ptr;
      else
        ap = ptr;
    end
    chk(8'(tptr), tp);
    chk(8'(aptr), ap);
  endtask : op

  // Load one window pointer
  task automatic load(input int a, input int pval);
    cpu.drive(8'h00, 2'(1 << a), 2'(pval), 8'h00, ul[0], 1'b1);
    if (a == 0)
      tp = pval;
    else
      ap = pval;
    chk(8'(tptr), tp);
    chk(8'(aptr), ap);
  endtask : load

  // Walk a window from pointer 11 down, low port then high port
  task automatic sweep(input int a, input int w);
    load(a, 3);
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      op(2 * a + 1, w, rnd, 1);
      rnd = lfsr(rnd);
      op(2 * a, w, rnd, 1);
    end
  endtask : sweep

  // Verdict and end of run
  task automatic tally_and_finish();
    if (error_cnt == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  // Fill, read, lock, then random traffic
  initial
  begin
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    for (int n = 0; n < 4; n++)
    begin
      ul = (n < 2) ? 1 : 0;
      sweep(0, n % 2 == 0);
      sweep(1, n % 2 == 0);
    end
    // Both pointers sit at 00: time load beside a high read, alarm write alongside
    rnd = lfsr(rnd);
    cpu.drive(8'h21, 2'h1, 2'h2, rnd, 1'b0, 1'b1);
    m[8] = rnd & msk[8];
    tp = 2;
    chk(8'(rd_valid_q), 1);
    chk(rd_data_q, m[1]);
    chk(8'(wr_discarded_q), 0);
    chk(v[8], m[8]);
    chk(8'(tptr), tp);
    chk(8'(aptr), ap);
    for (int i = 0; i < 400; i++)
    begin
      rnd = lfsr(rnd);
      ul = rnd[7];
      if (rnd[6:4] == 3'h0)
        load(rnd[3], rnd[1:0]);
      else
        op(rnd[3:2], rnd[1], lfsr(rnd), rnd[6:4] != 3'h7);
    end
    tally_and_finish();
  end

  // Watchdog well past the expected run length
  initial
  begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    tally_and_finish();
  end
endmodule : rtc_value_regs_tb
